// >>> hw/pgbc_pkg.sv
// shared constants for the four-pin port with bus control strobes
package pgbc_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   // printed offsets are not word aligned, so they are kept as indexes
   localparam int          PGBC_ADDR_W        = 18;          // byte address width
   localparam logic [15:0] PGBC_IDX_DIRECTION = 16'hffc9;    // direction register index
   localparam logic [15:0] PGBC_IDX_DATA      = 16'hffcb;    // data register index
   localparam logic [17:0] PGBC_ADDR_DIRECTION = {PGBC_IDX_DIRECTION, 2'b00};
   localparam logic [17:0] PGBC_ADDR_DATA      = {PGBC_IDX_DATA, 2'b00};

   // ***************************************************************
   // reset and initial values
   // ***************************************************************
   localparam logic [7:0]  PGBC_DIR_RESET     = 8'h80;       // value under async reset
   localparam logic [7:0]  PGBC_DIR_INIT_EXP  = 8'hf8;       // expanded modes
   localparam logic [7:0]  PGBC_DIR_INIT_SGL  = 8'h80;       // single-chip modes
   localparam logic [7:0]  PGBC_DATA_RESET    = 8'h80;       // data register
   localparam logic [7:0]  PGBC_DIR_READ      = 8'hff;       // direction reads as ones
   localparam logic [7:0]  PGBC_FIXED_MASK    = 8'h80;       // bit 7 fixed at one
   localparam logic [7:0]  PGBC_PIN_MASK      = 8'h39;       // bits 5, 4, 3, 0 are pins

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int          PGBC_BIT_PIN0      = 0;           // generic / wait pin
   localparam int          PGBC_BIT_PIN3      = 3;           // address strobe pin
   localparam int          PGBC_BIT_PIN4      = 4;           // read strobe pin
   localparam int          PGBC_BIT_PIN5      = 5;           // write strobe pin

   // ***************************************************************
   // modes and timing
   // ***************************************************************
   localparam logic [2:0]  PGBC_MODE_1        = 3'h1;        // expanded
   localparam logic [2:0]  PGBC_MODE_3        = 3'h3;        // expanded
   localparam logic [2:0]  PGBC_MODE_5        = 3'h5;        // expanded
   localparam logic [1:0]  PGBC_INIT_CYCLES   = 2'h3;        // edges before mode load
   localparam logic [1:0]  PGBC_RESP_OKAY     = 2'h0;        // axi okay
   localparam logic [1:0]  PGBC_RESP_SLVERR   = 2'h2;        // axi slave error

   // bus slave write state
   typedef enum logic [1:0] {PGBC_W_IDLE, PGBC_W_RESP} pgbc_wstate_type;

endpackage

// >>> hw/pgbc_port6.sv
// four-pin port shared with bus strobes, with axi4-lite register access
`timescale 1ns/1ps

module pgbc_port6
   import pgbc_pkg::*;
(
   input  wire logic                   CLOCK,
   input  wire logic                   RESET_N,
   // operating mode pins and standby controls
   input  wire logic [2:0]             MODE,
   input  wire logic                   HW_STANDBY_N,
   input  wire logic                   SW_STANDBY,
   // strobes from the bus controller, same clock
   input  wire logic                   BUS_WR_N,
   input  wire logic                   BUS_RD_N,
   input  wire logic                   ADDR_STROBE_N,
   output logic                        BUS_WAIT_N,
   // port pins: index 0 = pin 0, 1 = pin 3, 2 = pin 4, 3 = pin 5
   input  wire logic [3:0]             PORT_IN,
   output logic      [3:0]             PORT_OUT,
   output logic      [3:0]             PORT_OE,
   // axi4-lite slave
   input  wire logic [PGBC_ADDR_W-1:0] AWADDR,
   input  wire logic                   AWVALID,
   output logic                        AWREADY,
   input  wire logic [31:0]            WDATA,
   input  wire logic [3:0]             WSTRB,
   input  wire logic                   WVALID,
   output logic                        WREADY,
   output logic      [1:0]             BRESP,
   output logic                        BVALID,
   input  wire logic                   BREADY,
   input  wire logic [PGBC_ADDR_W-1:0] ARADDR,
   input  wire logic                   ARVALID,
   output logic                        ARREADY,
   output logic      [31:0]            RDATA,
   output logic      [1:0]             RRESP,
   output logic                        RVALID,
   input  wire logic                   RREADY
);

   // ***************************************************************
   // synchronised pin inputs
   // ***************************************************************
   logic [3:0] pin_sync;                  // port pin levels
   logic [3:0] ctl_sync;                  // mode pins and hardware standby

   pgbc_sync2 #(.WIDTH(4), .RESET_VAL(32'h0000000f)) u_pin_sync (
      .clk      (CLOCK),
      .reset_n  (RESET_N),
      .async_in (PORT_IN),
      .sync_out (pin_sync)
   );

   pgbc_sync2 #(.WIDTH(4), .RESET_VAL(32'h00000006)) u_ctl_sync (
      .clk      (CLOCK),
      .reset_n  (RESET_N),
      .async_in ({HW_STANDBY_N, MODE}),
      .sync_out (ctl_sync)
   );

   // ***************************************************************
   // mode decode
   // ***************************************************************
   wire [2:0] mode_now   = ctl_sync[2:0];          // synchronised mode
   wire       hw_standby = ~ctl_sync[3];           // hardware standby active
   wire       expanded   = (mode_now == PGBC_MODE_1) || (mode_now == PGBC_MODE_3) ||
                           (mode_now == PGBC_MODE_5);

   // ***************************************************************
   // state
   // ***************************************************************
   logic [7:0]       port6_direction_reg;   // direction register
   logic [7:0]       port6_direction_next;
   logic [7:0]       port6_output_data_reg; // data register
   logic [7:0]       port6_output_data_next;
   logic [1:0]       init_cnt_reg;          // edges since reset release
   logic             init_done_reg;         // mode-based value loaded
   logic             aw_held_reg;           // write address captured
   logic             w_held_reg;            // write data captured
   logic [PGBC_ADDR_W-1:0] aw_addr_reg;     // captured write address
   logic [7:0]       w_data_reg;            // captured write byte
   logic             w_lane_reg;            // byte lane 0 enabled
   pgbc_wstate_type  wstate_reg;            // write response state

   // ***************************************************************
   // initialisation sequencing
   // ***************************************************************
   // wait for synchronised mode pins before picking the initial value
   wire init_load = !init_done_reg && (init_cnt_reg == PGBC_INIT_CYCLES);
   wire [7:0] dir_init = expanded ? PGBC_DIR_INIT_EXP : PGBC_DIR_INIT_SGL;
   // bus is held off until initialised and outside any standby
   wire bus_open = init_done_reg && !hw_standby && !SW_STANDBY;

   // ***************************************************************
   // write channel decode
   // ***************************************************************
   wire aw_take   = AWVALID && AWREADY;
   wire w_take    = WVALID && WREADY;
   wire do_write  = aw_held_reg && w_held_reg && (wstate_reg == PGBC_W_IDLE);
   wire wr_dir    = (aw_addr_reg[PGBC_ADDR_W-1:2] == PGBC_IDX_DIRECTION);
   wire wr_data   = (aw_addr_reg[PGBC_ADDR_W-1:2] == PGBC_IDX_DATA);
   wire wr_mapped = wr_dir || wr_data;
   wire wr_go     = do_write && w_lane_reg;
   // reserved direction bits stored, pin logic ignores them
   wire [7:0] dir_wr_val  = (w_data_reg & ~PGBC_FIXED_MASK) | PGBC_FIXED_MASK;
   // bit 7 of data ignores writes
   wire [7:0] data_wr_val = (w_data_reg & ~PGBC_FIXED_MASK) | PGBC_FIXED_MASK;

   // ***************************************************************
   // register next values
   // ***************************************************************
   always_comb begin
      port6_direction_next   = port6_direction_reg;
      port6_output_data_next = port6_output_data_reg;
      if (hw_standby) begin
         port6_direction_next   = PGBC_DIR_RESET;
         port6_output_data_next = PGBC_DATA_RESET;
      end else if (init_load) begin
         port6_direction_next   = dir_init;
      end else if (wr_go && wr_dir) begin
         port6_direction_next   = dir_wr_val;
      end else if (wr_go && wr_data) begin
         port6_output_data_next = data_wr_val;
      end
   end

   // ***************************************************************
   // register file
   // ***************************************************************
   // software standby keeps contents, no load path
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         port6_direction_reg   <= PGBC_DIR_RESET;
         port6_output_data_reg <= PGBC_DATA_RESET;
      end else begin
         port6_direction_reg   <= port6_direction_next;
         port6_output_data_reg <= port6_output_data_next;
      end
   end

   // init counter, restarted by hardware standby
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         init_cnt_reg  <= 2'h0;
         init_done_reg <= 1'b0;
      end else if (hw_standby) begin
         init_cnt_reg  <= 2'h0;
         init_done_reg <= 1'b0;
      end else if (!init_done_reg) begin
         init_cnt_reg  <= init_cnt_reg + 2'h1;
         init_done_reg <= init_load;
      end
   end

   // ***************************************************************
   // axi write channels
   // ***************************************************************
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= 8'h00;
         w_lane_reg  <= 1'b0;
         wstate_reg  <= PGBC_W_IDLE;
         AWREADY     <= 1'b0;
         WREADY      <= 1'b0;
         BVALID      <= 1'b0;
         BRESP       <= PGBC_RESP_OKAY;
      end else begin
         // address capture
         if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= AWADDR;
         end else if (do_write) begin
            aw_held_reg <= 1'b0;
         end
         // data capture
         if (w_take) begin
            w_held_reg <= 1'b1;
            w_data_reg <= WDATA[7:0];
            w_lane_reg <= WSTRB[0];
         end else if (do_write) begin
            w_held_reg <= 1'b0;
         end
         // ready only while the slot is free
         AWREADY <= bus_open && !aw_held_reg && !aw_take && (wstate_reg == PGBC_W_IDLE);
         WREADY  <= bus_open && !w_held_reg && !w_take && (wstate_reg == PGBC_W_IDLE);
         case (wstate_reg)
            PGBC_W_IDLE: begin
               if (do_write) begin
                  BVALID     <= 1'b1;
                  BRESP      <= wr_mapped ? PGBC_RESP_OKAY : PGBC_RESP_SLVERR;
                  wstate_reg <= PGBC_W_RESP;
               end
            end
            PGBC_W_RESP: begin
               if (BREADY) begin
                  BVALID     <= 1'b0;
                  wstate_reg <= PGBC_W_IDLE;
               end
            end
            default: begin
               BVALID     <= 1'b0;
               wstate_reg <= PGBC_W_IDLE;
            end
         endcase
      end
   end

   // ***************************************************************
   // read value assembly
   // ***************************************************************
   // pin levels placed at their register bit positions
   // reserved positions carry no pin
   wire [7:0] pin_bits = {2'b00, pin_sync[3], pin_sync[2], pin_sync[1], 2'b00, pin_sync[0]};
   // pin bits: stored data if output, else pin level
   wire [7:0] pin_read = (port6_direction_reg & port6_output_data_reg) |
                         (~port6_direction_reg & pin_bits);
   // reserved bits: stored data if set, else one
   wire [7:0] rsv_read = (port6_direction_reg & port6_output_data_reg) |
                         ~port6_direction_reg;
   wire [7:0] data_read = (pin_read & PGBC_PIN_MASK) | (rsv_read & ~PGBC_PIN_MASK) |
                          PGBC_FIXED_MASK;
   wire       rd_dir    = (ARADDR[PGBC_ADDR_W-1:2] == PGBC_IDX_DIRECTION);
   wire       rd_data   = (ARADDR[PGBC_ADDR_W-1:2] == PGBC_IDX_DATA);
   wire       ar_take   = ARVALID && ARREADY;
   // direction register is write-only, reads ones
   wire [7:0] rd_byte   = rd_dir ? PGBC_DIR_READ : (rd_data ? data_read : 8'h00);

   // ***************************************************************
   // axi read channels
   // ***************************************************************
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b0;
         RDATA   <= 32'h00000000;
         RRESP   <= PGBC_RESP_OKAY;
      end else begin
         if (ar_take) begin
            RVALID <= 1'b1;
            RDATA  <= {24'h000000, rd_byte};
            RRESP  <= (rd_dir || rd_data) ? PGBC_RESP_OKAY : PGBC_RESP_SLVERR;
         end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
         end
         ARREADY <= bus_open && !ar_take && !(RVALID && !RREADY);
      end
   end

   // ***************************************************************
   // pin drive selection
   // ***************************************************************
   // direction bit one makes the pin an output
   wire [3:0] gen_oe  = {port6_direction_reg[PGBC_BIT_PIN5], port6_direction_reg[PGBC_BIT_PIN4],
                         port6_direction_reg[PGBC_BIT_PIN3], port6_direction_reg[PGBC_BIT_PIN0]};
   wire [3:0] gen_out = {port6_output_data_reg[PGBC_BIT_PIN5],
                         port6_output_data_reg[PGBC_BIT_PIN4],
                         port6_output_data_reg[PGBC_BIT_PIN3],
                         port6_output_data_reg[PGBC_BIT_PIN0]};
   // strobes on pins 5..3 in expanded modes
   wire [3:0] exp_out = {BUS_WR_N, BUS_RD_N, ADDR_STROBE_N, gen_out[0]};
   // pin 0 output only if its direction bit is set
   wire [3:0] exp_oe  = {3'b111, gen_oe[0]};
   wire [3:0] sel_out = expanded ? exp_out : gen_out;
   wire [3:0] sel_oe  = expanded ? exp_oe : gen_oe;
   // wait input taken from pin 0 when it is an input
   wire       wait_next = !(expanded && !gen_oe[0] && !pin_sync[0]);

   // ***************************************************************
   // pin output flops
   // ***************************************************************
   // four pins driven from flops
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         PORT_OUT   <= 4'h0;
         PORT_OE    <= 4'h0;
         BUS_WAIT_N <= 1'b1;
      end else if (hw_standby) begin
         // hardware standby floats every pin
         PORT_OUT   <= 4'h0;
         PORT_OE    <= 4'h0;
         BUS_WAIT_N <= 1'b1;
      end else if (SW_STANDBY) begin
         // output pins hold their state in software standby
         PORT_OUT   <= PORT_OUT;
         PORT_OE    <= PORT_OE;
         BUS_WAIT_N <= 1'b1;
      end else begin
         PORT_OUT   <= sel_out;
         PORT_OE    <= sel_oe;
         BUS_WAIT_N <= wait_next;
      end
   end

endmodule

// >>> hw/pgbc_sync2.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps

module pgbc_sync2 #(
   parameter int          WIDTH     = 1,
   parameter logic [31:0] RESET_VAL = 32'h0
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   // first stage, read only by the second stage
   logic [WIDTH-1:0] meta_reg;

   // ***************************************************************
   // two stage capture
   // ***************************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= RESET_VAL[WIDTH-1:0];
         sync_out <= RESET_VAL[WIDTH-1:0];
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// >>> testbench/pgbc_pin_model.sv
// external devices on the four port pins
`timescale 1ns/1ps

module pgbc_pin_model (
   input  wire logic [3:0] port_out,
   input  wire logic [3:0] port_oe,
   input  wire logic [3:0] ext_level,
   output logic      [3:0] pin_level
);
   // pin resolves to the port drive when enabled, else the outside device
   assign pin_level = (port_oe & port_out) | (~port_oe & ext_level);
endmodule

// >>> testbench/pgbc_port6_properties.sv
// concurrent checks on the port pins and register bus of pgbc_port6
`timescale 1ns/1ps

module pgbc_port6_chk
   import pgbc_pkg::*;
(
   input wire logic                   CLOCK,
   input wire logic                   RESET_N,
   input wire logic [2:0]             MODE,
   input wire logic                   HW_STANDBY_N,
   input wire logic                   SW_STANDBY,
   input wire logic                   BUS_WR_N,
   input wire logic                   BUS_RD_N,
   input wire logic                   ADDR_STROBE_N,
   input wire logic                   BUS_WAIT_N,
   input wire logic [3:0]             PORT_OUT,
   input wire logic [3:0]             PORT_OE,
   input wire logic [PGBC_ADDR_W-1:0] ARADDR,
   input wire logic                   ARVALID,
   input wire logic                   ARREADY,
   input wire logic [31:0]            RDATA,
   input wire logic [1:0]             RRESP,
   input wire logic                   RVALID,
   input wire logic                   RREADY,
   input wire logic                   BVALID,
   input wire logic                   BREADY
);
   // ***************************************************************
   // helper logic
   // ***************************************************************
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   logic ar_dir_reg;  // read in flight targets direction
   logic ar_dat_reg;  // read in flight targets data
   wire  exp_w   = (MODE == PGBC_MODE_1) || (MODE == PGBC_MODE_3) || (MODE == PGBC_MODE_5);
   wire  quiet_w = HW_STANDBY_N && !SW_STANDBY;  // no standby of any kind
   // remember the target of the accepted read
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         ar_dir_reg <= 1'b0;
         ar_dat_reg <= 1'b0;
      end else if (ARVALID && ARREADY) begin
         ar_dir_reg <= (ARADDR == PGBC_ADDR_DIRECTION);
         ar_dat_reg <= (ARADDR == PGBC_ADDR_DATA);
      end
   end
   // ***************************************************************
   // assertions
   // ***************************************************************
   chk_rvalid_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read answer dropped early");
   chk_bvalid_hold: assert property (BVALID && !BREADY |=> BVALID)
      else $error("write answer dropped early");
   chk_dir_ones: assert property (RVALID && ar_dir_reg |-> RDATA[7:0] == PGBC_DIR_READ)
      else $error("direction read not all ones");
   chk_data_bit7: assert property (RVALID && ar_dat_reg |-> RDATA[7])
      else $error("data bit 7 read as zero");
   chk_exp_strobes: assert property ((exp_w && quiet_w)[*8] |=> PORT_OE[3:1] == 3'b111
      && PORT_OUT[3:1] == {$past(BUS_WR_N), $past(BUS_RD_N), $past(ADDR_STROBE_N)})
      else $error("strobe pins not following bus controller");
   chk_single_nowait: assert property ((!exp_w && quiet_w)[*8] |=> BUS_WAIT_N)
      else $error("wait raised in single-chip mode");
   chk_wait_input: assert property (!BUS_WAIT_N |-> !PORT_OE[0] && exp_w)
      else $error("wait low while pin0 driven");
   chk_sw_freeze: assert property ((SW_STANDBY && HW_STANDBY_N)[*3] |=> $stable(PORT_OE)
      && $stable(PORT_OUT))
      else $error("pins changed in software standby");
   cov_exp: cover property ((exp_w && quiet_w)[*8]);
   cov_wait: cover property (!BUS_WAIT_N);
   cov_sw: cover property (SW_STANDBY[*3]);
endmodule

bind pgbc_port6 pgbc_port6_chk chk_u (.CLOCK(CLOCK), .RESET_N(RESET_N), .MODE(MODE),
   .HW_STANDBY_N(HW_STANDBY_N), .SW_STANDBY(SW_STANDBY), .BUS_WR_N(BUS_WR_N),
   .BUS_RD_N(BUS_RD_N), .ADDR_STROBE_N(ADDR_STROBE_N), .BUS_WAIT_N(BUS_WAIT_N),
   .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE), .ARADDR(ARADDR), .ARVALID(ARVALID),
   .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
   .BVALID(BVALID), .BREADY(BREADY));

// >>> testbench/tb.sv
// self-checking bench for pgbc_port6
`timescale 1ns/1ps

module tb;
   import pgbc_pkg::*;
   logic CLOCK = 0, RESET_N = 0, HW_STANDBY_N = 1, SW_STANDBY = 0;
   logic BUS_WR_N = 1, BUS_RD_N = 1, ADDR_STROBE_N = 1, BUS_WAIT_N;
   logic [2:0] MODE = 3'h7;
   logic [3:0] PORT_IN, PORT_OUT, PORT_OE, WSTRB = 4'hf, ext_level = 4'ha;
   logic [17:0] AWADDR = 18'h0, ARADDR = 18'h0;
   logic [31:0] WDATA = 32'h0, RDATA;
   logic [1:0] BRESP, RRESP, resp;
   logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [7:0] rd_val;
   int n_mismatch = 0, comparisons = 0, cyc = 0;

   always #25 CLOCK = ~CLOCK;
   pgbc_port6 dut_u (.CLOCK(CLOCK), .RESET_N(RESET_N), .MODE(MODE),
      .HW_STANDBY_N(HW_STANDBY_N), .SW_STANDBY(SW_STANDBY), .BUS_WR_N(BUS_WR_N),
      .BUS_RD_N(BUS_RD_N), .ADDR_STROBE_N(ADDR_STROBE_N), .BUS_WAIT_N(BUS_WAIT_N),
      .PORT_IN(PORT_IN), .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE), .AWADDR(AWADDR),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
      .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
      .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY));
   pgbc_pin_model pins_u (.port_out(PORT_OUT), .port_oe(PORT_OE), .ext_level(ext_level),
      .pin_level(PORT_IN));

   // ***************************************************************
   // shared tasks
   // ***************************************************************
   task automatic report_and_stop;
      if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // compare one value
   task automatic ck(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   // reset into a given mode, then let the init sequence finish
   task automatic do_reset(input logic [2:0] m);
      @(posedge CLOCK);
      RESET_N <= 1'b0;
      MODE <= m;
      repeat (16) @(posedge CLOCK);
      RESET_N <= 1'b1;
      repeat (10) @(posedge CLOCK);
   endtask
   // one write, address and data offered together
   task automatic wr(input logic [17:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      AWADDR <= a;
      WDATA <= {24'h0, d};
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
      end while (!BVALID);
      ck({6'h0, BRESP}, {6'h0, PGBC_RESP_OKAY});
      BREADY <= 1'b0;
      repeat (2) @(posedge CLOCK);
   endtask
   // one read, byte and response returned
   task automatic rd(input logic [17:0] a, output logic [7:0] d, output logic [1:0] r);
      @(posedge CLOCK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (ARREADY) ARVALID <= 1'b0;
      end while (!RVALID);
      d = RDATA[7:0];
      r = RRESP;
      RREADY <= 1'b0;
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   // single-chip register reads, writes and reserved bits
   task automatic sc_single;
      do_reset(PGBC_MODE_1 ^ 3'h6);
      ck({4'h0, PORT_OE}, 8'h00);
      rd(PGBC_ADDR_DIRECTION, rd_val, resp);
      ck(rd_val, 8'hff);
      rd(PGBC_ADDR_DATA, rd_val, resp);
      ck(rd_val, 8'hee);
      wr(PGBC_ADDR_DATA, 8'h00);
      wr(PGBC_ADDR_DIRECTION, 8'h46);
      rd(PGBC_ADDR_DATA, rd_val, resp);
      ck(rd_val, 8'ha8);
      ck({4'h0, PORT_OE}, 8'h00);
      wr(PGBC_ADDR_DIRECTION, 8'h7f);
      rd(PGBC_ADDR_DATA, rd_val, resp);
      ck(rd_val, 8'h80);
      ck({PORT_OE, PORT_OUT}, 8'hf0);
      wr(PGBC_ADDR_DATA, 8'hff);
      WSTRB <= 4'h0;
      wr(PGBC_ADDR_DATA, 8'h00);
      WSTRB <= 4'hf;
      rd(PGBC_ADDR_DATA, rd_val, resp);
      ck({rd_val[3:0], PORT_OUT}, 8'hff);
      wr(PGBC_ADDR_DIRECTION, 8'h00);
      rd(PGBC_ADDR_DATA, rd_val, resp);
      ck(rd_val, 8'hee);
      rd(18'h00010, rd_val, resp);
      ck({6'h0, resp}, {6'h0, PGBC_RESP_SLVERR});
   endtask
   // software standby keeps, hardware standby reinitialises
   task automatic sc_standby;
      wr(PGBC_ADDR_DIRECTION, 8'h39);
      wr(PGBC_ADDR_DATA, 8'h39);
      SW_STANDBY <= 1'b1;
      repeat (6) @(posedge CLOCK);
      ck({PORT_OE, PORT_OUT}, 8'hff);
      SW_STANDBY <= 1'b0;
      rd(PGBC_ADDR_DATA, rd_val, resp);
      ck(rd_val, 8'hff);
      repeat (3) @(posedge CLOCK);
      HW_STANDBY_N <= 1'b0;
      repeat (6) @(posedge CLOCK);
      HW_STANDBY_N <= 1'b1;
      repeat (12) @(posedge CLOCK);
      ck({4'h0, PORT_OE}, 8'h00);
      wr(PGBC_ADDR_DIRECTION, 8'h7f);
      rd(PGBC_ADDR_DATA, rd_val, resp);
      ck(rd_val, PGBC_DATA_RESET);
   endtask
   // expanded mode strobes and wait pin
   task automatic sc_expanded;
      do_reset(PGBC_MODE_1);
      ck({4'h0, PORT_OE}, 8'h0e);
      rd(PGBC_ADDR_DATA, rd_val, resp);
      ck(rd_val, 8'h86);
      BUS_WR_N <= 1'b0;
      ADDR_STROBE_N <= 1'b0;
      repeat (3) @(posedge CLOCK);
      ck({5'h0, PORT_OUT[3:1]}, 8'h02);
      ck({7'h0, BUS_WAIT_N}, 8'h00);
      wr(PGBC_ADDR_DIRECTION, 8'h01);
      wr(PGBC_ADDR_DATA, 8'h01);
      ck({3'h0, BUS_WAIT_N, PORT_OE}, 8'h1f);
      ck({7'h0, PORT_OUT[0]}, 8'h01);
      wr(PGBC_ADDR_DIRECTION, 8'h00);
      ck({4'h0, PORT_OE}, 8'h0e);
      BUS_WR_N <= 1'b1;
      ADDR_STROBE_N <= 1'b1;
      do_reset(PGBC_MODE_3);
      ck({4'h0, PORT_OE}, 8'h0e);
      do_reset(PGBC_MODE_5);
      ck({4'h0, PORT_OE}, 8'h0e);
   endtask

   // ***************************************************************
   // watchdog and main sequence
   // ***************************************************************
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop;
      end
   end
   initial begin
      sc_single;
      sc_standby;
      sc_expanded;
      report_and_stop;
   end
endmodule
